// >>> verilog/rct_regs.vh
// Overview of operation
// - count command code enters rapid count mode
// - count mode shows five dashes on left
// - reciprocal count: cycles and 2 MHz ticks
// - stream four-byte groups, no delimiters, until exit
// - any bus command or data ends count
// - pack clock and cycle counts with biases
// - tune command code enters rapid tune mode
// - five tuning bytes applied straight to source
// - every tuning byte has upper nibble 0011
// - coarse and fine split into nibble pairs
// - key press or attention ends tune mode
// - leveling loop off during tune mode
// - same range retune keeps phase continuous
// - source programmed within three milliseconds
// - functions 55-57 read back or zero settings
// - tune mode shows five dashes on left
`ifndef RCT_REGS_VH
`define RCT_REGS_VH

// command characters
`define RCT_CHAR_LEAD      8'h52
`define RCT_CHAR_COUNT     8'h46
`define RCT_CHAR_TUNE      8'h53

// tuning byte layout
`define RCT_TUNE_HDR       4'h3
`define RCT_TUNE_BYTES     3'h5
`define RCT_IDX_COARSE_LO  3'h0
`define RCT_IDX_COARSE_HI  3'h1
`define RCT_IDX_FINE_LO    3'h2
`define RCT_IDX_FINE_HI    3'h3
`define RCT_IDX_RANGE      3'h4

// special function numbers
`define RCT_SF_RANGE       7'h37
`define RCT_SF_COARSE      7'h38
`define RCT_SF_FINE        7'h39

// counter timing
`define RCT_CLK_MHZ        200
`define RCT_REF_KHZ        2000
`define RCT_REF_DIV        ((`RCT_CLK_MHZ * 1000) / `RCT_REF_KHZ)
`define RCT_GATE_TICKS     5120
`define RCT_CLK_LIMIT      19'h413ff
`define RCT_CYC_FULL       12'hffe

// packing biases
`define RCT_CLK_HI_BIAS    9'h104
`define RCT_CYC_HI_BIAS    8'hff

// source programming window
`define RCT_PROG_TIME_US   3000
`define RCT_PROG_CYCLES    (`RCT_PROG_TIME_US * `RCT_CLK_MHZ)

`endif

// >>> verilog/rct_sync.v
`timescale 1ns/10ps
`default_nettype none

module rct_sync #(
    parameter WIDTH = 3
) (
    input  wire             clock,
    input  wire             rst,
    input  wire [WIDTH-1:0] d_in,
    output reg  [WIDTH-1:0] q_out
);
    reg [WIDTH-1:0] meta_reg;

    // two-stage synchroniser; first stage feeds nothing else
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_reg <= {WIDTH{1'b0}};
            q_out    <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule // rct_sync

`default_nettype wire

// >>> verilog/rct_recip_counter.v
`timescale 1ns/10ps
`default_nettype none
`include "rct_regs.vh"

module rct_recip_counter #(
    parameter REF_DIV    = `RCT_REF_DIV,
    parameter GATE_TICKS = `RCT_GATE_TICKS
) (
    input  wire        clock,
    input  wire        rst,
    input  wire        enable,
    input  wire        sig_in,
    output reg         res_valid,
    output reg  [18:0] res_clocks,
    output reg  [11:0] res_cycles
);
    localparam [31:0] DIV_WORD  = REF_DIV - 1;
    localparam [31:0] GATE_WORD = GATE_TICKS;
    localparam [6:0]  DIV_LAST  = DIV_WORD[6:0];
    localparam [18:0] GATE      = GATE_WORD[18:0];

    reg  [6:0]  div_reg;
    reg         sig_d_reg;
    reg         run_reg;
    reg  [18:0] clk_cnt_reg;
    reg  [11:0] cyc_cnt_reg;
    wire        tick;
    wire        rise;
    wire [18:0] clk_now;

    assign tick    = (div_reg == DIV_LAST);
    assign rise    = sig_in & ~sig_d_reg;
    assign clk_now = clk_cnt_reg + {18'h0, tick};

    // reciprocal gate
    // start on an input edge, stop on the first edge past the gate;
    // the free divider costs at most one tick of resolution
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            div_reg     <= 7'h0;
            sig_d_reg   <= 1'b0;
            run_reg     <= 1'b0;
            clk_cnt_reg <= 19'h0;
            cyc_cnt_reg <= 12'h0;
            res_valid   <= 1'b0;
            res_clocks  <= 19'h0;
            res_cycles  <= 12'h0;
        end else begin
            sig_d_reg <= sig_in;
            div_reg   <= tick ? 7'h0 : div_reg + 7'h1;
            res_valid <= 1'b0;
            if (!enable) begin
                run_reg <= 1'b0;
            end else if (!run_reg) begin
                if (rise) begin
                    run_reg     <= 1'b1;
                    clk_cnt_reg <= 19'h0;
                    cyc_cnt_reg <= 12'h0;
                end
            end else if (rise && clk_now >= GATE) begin
                res_valid   <= 1'b1;
                res_clocks  <= clk_now;
                res_cycles  <= cyc_cnt_reg + 12'h1;
                clk_cnt_reg <= 19'h0;
                cyc_cnt_reg <= 12'h0;
            end else if (clk_now >= `RCT_CLK_LIMIT ||
                         (rise && cyc_cnt_reg == `RCT_CYC_FULL)) begin
                // result would not fit the packed form: rearm
                run_reg <= 1'b0;
            end else begin
                clk_cnt_reg <= clk_now;
                if (rise)
                    cyc_cnt_reg <= cyc_cnt_reg + 12'h1;
            end
        end
    end
endmodule // rct_recip_counter

`default_nettype wire

// >>> verilog/rct_port.v
`timescale 1ns/10ps
`default_nettype none
`include "rct_regs.vh"

module rct_port #(
    parameter PROG_CYCLES = `RCT_PROG_CYCLES,
    parameter REF_DIV     = `RCT_REF_DIV,
    parameter GATE_TICKS  = `RCT_GATE_TICKS
) (
    input  wire        clock,
    input  wire        rst,
    input  wire        rx_valid,
    input  wire [7:0]  rx_data,
    input  wire        atn_pin,
    input  wire        key_pin,
    input  wire        sig_pin,
    output wire        tx_valid,
    output wire [7:0]  tx_data,
    input  wire        tx_ready,
    output wire        left_dashes,
    output wire        level_loop_en,
    output wire        count_active,
    output wire        tune_active,
    output reg  [3:0]  src_range,
    output reg  [7:0]  src_coarse,
    output reg  [7:0]  src_fine,
    output reg         src_load,
    output reg         src_phase_reset,
    output wire        src_busy,
    input  wire        sf_valid,
    input  wire [6:0]  sf_number,
    input  wire        sf_zero,
    output reg         sf_rd_valid,
    output reg  [7:0]  sf_rd_data
);
    localparam [1:0] MODE_IDLE  = 2'h0;
    localparam [1:0] MODE_COUNT = 2'h1;
    localparam [1:0] MODE_TUNE  = 2'h2;
    localparam       BW         = $clog2(PROG_CYCLES + 1);
    localparam [31:0]   PROG_WORD = PROG_CYCLES;
    localparam [BW-1:0] PROG_LOAD = PROG_WORD[BW-1:0];

    reg  [1:0]    mode_reg;
    reg  [1:0]    mode_next;
    reg  [7:0]    prev_char_reg;
    reg  [2:0]    tune_idx_reg;
    reg  [3:0]    coarse_lo_reg;
    reg  [3:0]    coarse_hi_reg;
    reg  [3:0]    fine_lo_reg;
    reg  [3:0]    fine_hi_reg;
    reg  [31:0]   tx_buf_reg;
    reg  [2:0]    tx_left_reg;
    reg  [BW-1:0] busy_cnt_reg;
    wire [2:0]    sync_q;
    wire          atn_s;
    wire          key_s;
    wire          sig_s;
    wire          res_valid;
    wire [18:0]   res_clocks;
    wire [11:0]   res_cycles;
    wire          hit_count;
    wire          hit_tune;
    wire          tune_byte;
    wire          hdr_ok;
    wire          word_done;
    wire [1:0]    sf_sel;
    wire [8:0]    clk_hi_code;

    // match a two-character command ending in the given character
    function cmd_hit;
        input [7:0] prev_c;
        input [7:0] cur_c;
        input [7:0] second_c;
        begin
            cmd_hit = (prev_c == `RCT_CHAR_LEAD) && (cur_c == second_c);
        end
    endfunction

    // map a special function number to the value it addresses
    function [1:0] sf_decode;
        input [6:0] num;
        begin
            case (num)
                `RCT_SF_RANGE:  sf_decode = 2'h1;
                `RCT_SF_COARSE: sf_decode = 2'h2;
                `RCT_SF_FINE:   sf_decode = 2'h3;
                default:        sf_decode = 2'h0;
            endcase
        end
    endfunction

    // pins come from outside the clock domain
    rct_sync #(
        .WIDTH (3)
    ) u_sync (
        .clock (clock),
        .rst   (rst),
        .d_in  ({atn_pin, key_pin, sig_pin}),
        .q_out (sync_q)
    );

    assign atn_s = sync_q[2];
    assign key_s = sync_q[1];
    assign sig_s = sync_q[0];

    // counter runs only in count mode
    rct_recip_counter #(
        .REF_DIV    (REF_DIV),
        .GATE_TICKS (GATE_TICKS)
    ) u_counter (
        .clock      (clock),
        .rst        (rst),
        .enable     (mode_reg == MODE_COUNT),
        .sig_in     (sig_s),
        .res_valid  (res_valid),
        .res_clocks (res_clocks),
        .res_cycles (res_cycles)
    );

    // command decoding of incoming program characters
    assign hit_count = rx_valid &&
                       cmd_hit(prev_char_reg, rx_data, `RCT_CHAR_COUNT);
    assign hit_tune  = rx_valid &&
                       cmd_hit(prev_char_reg, rx_data, `RCT_CHAR_TUNE);

    assign tune_byte = rx_valid && (mode_reg == MODE_TUNE) && !atn_s &&
                       !key_s;
    assign hdr_ok    = (rx_data[7:4] == `RCT_TUNE_HDR);
    assign word_done = tune_byte && hdr_ok &&
                       (tune_idx_reg == `RCT_TUNE_BYTES - 3'h1);

    // mode selection
    always @* begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_IDLE: begin
                if (hit_count)
                    mode_next = MODE_COUNT;
                else if (hit_tune)
                    mode_next = MODE_TUNE;
            end
            MODE_COUNT: begin
                // any command or new data ends count
                if (atn_s || rx_valid)
                    mode_next = MODE_IDLE;
            end
            MODE_TUNE: begin
                if (atn_s || key_s)
                    mode_next = MODE_IDLE;
            end
            default: begin
                mode_next = MODE_IDLE;
            end
        endcase
    end

    // mode and command character history
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_reg      <= MODE_IDLE;
            prev_char_reg <= 8'h0;
        end else begin
            mode_reg <= mode_next;
            if (mode_next == MODE_TUNE)
                prev_char_reg <= 8'h0;  // tuning bytes are not commands
            else if (rx_valid)
                prev_char_reg <= rx_data;
        end
    end

    assign left_dashes   = (mode_reg != MODE_IDLE);
    assign level_loop_en = (mode_reg != MODE_TUNE);
    assign count_active  = (mode_reg == MODE_COUNT);
    assign tune_active   = (mode_reg == MODE_TUNE);

    // coarse and fine in nibble pairs
    // a byte with a wrong upper nibble drops the partial word
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            tune_idx_reg  <= 3'h0;
            coarse_lo_reg <= 4'h0;
            coarse_hi_reg <= 4'h0;
            fine_lo_reg   <= 4'h0;
            fine_hi_reg   <= 4'h0;
        end else if (mode_reg != MODE_TUNE) begin
            tune_idx_reg <= 3'h0;
        end else if (tune_byte) begin
            if (!hdr_ok || word_done)
                tune_idx_reg <= 3'h0;
            else
                tune_idx_reg <= tune_idx_reg + 3'h1;
            if (hdr_ok) begin
                case (tune_idx_reg)
                    `RCT_IDX_COARSE_LO: coarse_lo_reg <= rx_data[3:0];
                    `RCT_IDX_COARSE_HI: coarse_hi_reg <= rx_data[3:0];
                    `RCT_IDX_FINE_LO:   fine_lo_reg   <= rx_data[3:0];
                    `RCT_IDX_FINE_HI:   fine_hi_reg   <= rx_data[3:0];
                    default:            fine_hi_reg   <= fine_hi_reg;
                endcase
            end
        end
    end

    assign sf_sel = sf_valid ? sf_decode(sf_number) : 2'h0;

    // source settings: tune words and special function zeroing
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            src_range       <= 4'h0;
            src_coarse      <= 8'h0;
            src_fine        <= 8'h0;
            src_load        <= 1'b0;
            src_phase_reset <= 1'b0;
            sf_rd_valid     <= 1'b0;
            sf_rd_data      <= 8'h0;
        end else begin
            src_load        <= 1'b0;
            src_phase_reset <= 1'b0;
            sf_rd_valid     <= 1'b0;
            if (word_done) begin
                // whole word applied in one cycle
                src_coarse <= {coarse_hi_reg, coarse_lo_reg};
                src_fine   <= {fine_hi_reg, fine_lo_reg};
                src_range  <= rx_data[3:0];
                src_load   <= 1'b1;
                // no phase reset within a range
                src_phase_reset <= (rx_data[3:0] != src_range);
            end else if (sf_sel != 2'h0) begin
                if (sf_zero) begin
                    case (sf_sel)
                        2'h1: src_range  <= 4'h0;
                        2'h2: src_coarse <= 8'h0;
                        default: src_fine <= 8'h0;
                    endcase
                    src_load        <= 1'b1;
                    src_phase_reset <= (sf_sel == 2'h1) &&
                                       (src_range != 4'h0);
                end else begin
                    sf_rd_valid <= 1'b1;
                    case (sf_sel)
                        2'h1: sf_rd_data <= {4'h0, src_range};
                        2'h2: sf_rd_data <= src_coarse;
                        default: sf_rd_data <= src_fine;
                    endcase
                end
            end
        end
    end

    // programming window bounded by three ms
    always @(posedge clock or posedge rst) begin
        if (rst)
            busy_cnt_reg <= {BW{1'b0}};
        else if (src_load)
            busy_cnt_reg <= PROG_LOAD;
        else if (busy_cnt_reg != {BW{1'b0}})
            busy_cnt_reg <= busy_cnt_reg - {{(BW-1){1'b0}}, 1'b1};
    end

    assign src_busy = (busy_cnt_reg != {BW{1'b0}});

    assign clk_hi_code = `RCT_CLK_HI_BIAS - res_clocks[18:10];

    // four-byte groups, no delimiter
    // a result that lands while a group is still leaving is dropped,
    // so a slow controller sees fewer groups, each whole unless count mode ends while it is leaving
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_buf_reg  <= 32'h0;
            tx_left_reg <= 3'h0;
        end else if (mode_reg != MODE_COUNT) begin
            tx_left_reg <= 3'h0;
        end else if (tx_left_reg == 3'h0) begin
            if (res_valid) begin
                tx_buf_reg <= {clk_hi_code[7:0],
                               res_clocks[3:0], res_clocks[7:4],
                               `RCT_CYC_HI_BIAS - res_cycles[11:4],
                               2'h0, res_clocks[9:8], res_cycles[3:0]};
                tx_left_reg <= 3'h4;
            end
        end else if (tx_ready) begin
            tx_buf_reg  <= {tx_buf_reg[23:0], 8'h0};
            tx_left_reg <= tx_left_reg - 3'h1;
        end
    end

    // handshake output comes straight from the byte count, gated by count mode
    assign tx_valid = (mode_reg == MODE_COUNT) && (tx_left_reg != 3'h0);
    assign tx_data  = tx_buf_reg[31:24];
endmodule // rct_port

`default_nettype wire

// >>> bench/rct_port_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "rct_regs.vh"

// watches the port's outputs against its inputs
module rct_port_props #(
    parameter PROG_CYCLES = 20
) (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic       atn_pin,
    input wire logic       key_pin,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_ready,
    input wire logic       left_dashes,
    input wire logic       level_loop_en,
    input wire logic       count_active,
    input wire logic       tune_active,
    input wire logic [3:0] src_range,
    input wire logic [7:0] src_fine,
    input wire logic [7:0] src_coarse,
    input wire logic       src_load,
    input wire logic       src_phase_reset,
    input wire logic       src_busy,
    input wire logic       sf_valid,
    input wire logic [6:0] sf_number,
    input wire logic       sf_zero,
    input wire logic       sf_rd_valid,
    input wire logic [7:0] sf_rd_data
);
    logic [7:0]  last_byte_reg;
    logic [31:0] busy_cnt_reg;

    // previous program byte and the expected programming window
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            last_byte_reg <= 8'h00;
            busy_cnt_reg  <= 32'h0;
        end else begin
            if (tune_active)
                last_byte_reg <= 8'h00;  // tuning bytes are no commands
            else if (rx_valid)
                last_byte_reg <= rx_data;
            if (src_load)
                busy_cnt_reg <= PROG_CYCLES;
            else if (busy_cnt_reg != 32'h0)
                busy_cnt_reg <= busy_cnt_reg - 32'h1;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    chk_dash_show: assert property (
        left_dashes == (count_active || tune_active))
        else $error("left dashes disagree with mode");
    chk_level_off: assert property (
        level_loop_en == !tune_active)
        else $error("leveling loop wrong for mode");
    chk_count_entry: assert property (
        rx_valid && rx_data == `RCT_CHAR_COUNT && !tune_active
        && last_byte_reg == `RCT_CHAR_LEAD && !count_active |=> count_active)
        else $error("count command not taken");
    chk_tune_entry: assert property (
        rx_valid && rx_data == `RCT_CHAR_TUNE && !count_active && !tune_active
        && last_byte_reg == `RCT_CHAR_LEAD && !atn_pin && !key_pin
        |=> tune_active)
        else $error("tune command not taken");
    chk_count_byte: assert property (
        count_active && rx_valid |=> !count_active)
        else $error("count mode survived a byte");
    chk_count_atn: assert property (
        (count_active && atn_pin) [*3] |=> !count_active)
        else $error("count mode survived attention");
    chk_tune_exit: assert property (
        (tune_active && (atn_pin || key_pin)) [*3] |=> !tune_active)
        else $error("tune mode survived key or attention");
    chk_tx_mode: assert property (
        tx_valid |-> count_active)
        else $error("count byte offered outside count mode");
    chk_tx_hold: assert property (
        tx_valid && !tx_ready ##1 count_active |-> tx_valid && $stable(tx_data))
        else $error("count byte dropped or changed while stalled");
    chk_phase_cont: assert property (
        src_load |-> src_phase_reset == (src_range != $past(src_range)))
        else $error("phase reset wrong for range change");
    chk_busy_window: assert property (
        src_busy == (busy_cnt_reg != 32'h0))
        else $error("programming window length wrong");
    chk_sf_read: assert property (
        sf_valid && !sf_zero && sf_number == `RCT_SF_COARSE && !rx_valid
        |=> sf_rd_valid && sf_rd_data == $past(src_coarse))
        else $error("coarse readback wrong");
    chk_sf_zero: assert property (
        sf_valid && sf_zero && sf_number == `RCT_SF_FINE && !rx_valid
        |=> src_load && src_fine == 8'h00)
        else $error("fine zeroing wrong");
endmodule // rct_port_props

bind rct_port rct_port_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
    .clock, .rst, .rx_valid, .rx_data, .atn_pin, .key_pin, .tx_valid,
    .tx_data, .tx_ready, .left_dashes, .level_loop_en, .count_active,
    .tune_active, .src_range, .src_fine, .src_coarse, .src_load,
    .src_phase_reset, .src_busy, .sf_valid, .sf_number, .sf_zero,
    .sf_rd_valid, .sf_rd_data
);

`default_nettype wire

// >>> bench/rct_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

// stands in for the remote controller on the bus
module rct_ctrl_model (
    input  wire logic       clock,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output var  logic       tx_ready,
    output var  logic       rx_valid,
    output var  logic [7:0] rx_data,
    output var  logic       atn_pin
);
    logic        slow;
    int          taken;
    logic [31:0] got;

    initial begin
        slow     = 1'b0;
        taken    = 0;
        got      = 32'h0;
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        atn_pin  = 1'b0;
    end

    // takes count bytes as they come
    // alternate stalls when slow so the talker has to hold its byte
    always @(negedge clock) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    always @(posedge clock) begin
        if (tx_valid && tx_ready) begin
            taken <= taken + 1;
            got   <= {got[23:0], tx_data};
        end
    end

    // one pulse per byte, no other bus activity
    // line scrambled between bytes so a stale value never looks valid
    task automatic send_byte(input logic [7:0] b);
        @(negedge clock);
        rx_valid = 1'b1;
        rx_data  = b;
        @(negedge clock);
        rx_valid = 1'b0;
        rx_data  = ~b;
    endtask

    // five bytes, header 0011, low nibble first
    task automatic send_tune(input logic [7:0] c, input logic [7:0] f,
                             input logic [3:0] r);
        send_byte({4'h3, c[3:0]});
        send_byte({4'h3, c[7:4]});
        send_byte({4'h3, f[3:0]});
        send_byte({4'h3, f[7:4]});
        send_byte({4'h3, r});
    endtask
endmodule // rct_ctrl_model

`default_nettype wire

// >>> bench/test_rct_port.sv
`timescale 1ns/10ps
`default_nettype none

module test_rct_port;
    localparam int PROG = 20;
    logic       clock, rst, key_pin, sig_pin, sf_valid, sf_zero;
    logic [6:0] sf_number;
    wire        rx_valid, atn_pin, tx_valid, tx_ready, left_dashes;
    wire        level_loop_en, count_active, tune_active, src_load;
    wire        src_phase_reset, src_busy, sf_rd_valid;
    wire  [7:0] rx_data, tx_data, src_coarse, src_fine, sf_rd_data;
    wire  [3:0] src_range;
    int         error_cnt, cmp_count;

    // short programming window and a tick every clock keep the run brief
    rct_port #(.PROG_CYCLES(PROG), .REF_DIV(1)) dut (
        .clock, .rst, .rx_valid, .rx_data, .atn_pin, .key_pin, .sig_pin,
        .tx_valid, .tx_data, .tx_ready, .left_dashes, .level_loop_en,
        .count_active, .tune_active, .src_range, .src_coarse, .src_fine,
        .src_load, .src_phase_reset, .src_busy, .sf_valid, .sf_number,
        .sf_zero, .sf_rd_valid, .sf_rd_data
    );
    rct_ctrl_model u_ctrl (
        .clock, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data, .atn_pin
    );

    // clock and a measured signal that keeps the counter busy
    always #2.5 clock = ~clock;
    always @(negedge clock) sig_pin <= ~sig_pin;

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        cmp_count++;
        if (seen !== want) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic enter(input logic [7:0] ch);
        u_ctrl.send_byte(8'h52);
        u_ctrl.send_byte(ch);
    endtask

    task automatic tune_word(input logic [7:0] c, input logic [7:0] f,
                             input logic [3:0] r, input logic ph);
        int n;
        u_ctrl.send_tune(c, f, r);
        n = 0;
        while (!src_load && n < 10) begin
            n++;
            @(negedge clock);
        end
        check(src_load, 1'b1);
        check(src_coarse, c);
        check(src_fine, f);
        check(src_range, r);
        check(src_phase_reset, ph);
        n = 0;
        // wait out the programming window before the next word
        @(negedge clock);
        while (src_busy && n < 100) begin
            n++;
            @(negedge clock);
        end
        check(8'(n), 8'(PROG));
    endtask

    task automatic sf_op(input logic [6:0] num, input logic z);
        @(negedge clock);
        sf_valid  = 1'b1;
        sf_number = num;
        sf_zero   = z;
        @(negedge clock);
        sf_valid  = 1'b0;
    endtask

    task automatic t_tune;
        enter(8'h53);
        check(tune_active, 1'b1);
        check(left_dashes, 1'b1);
        check(level_loop_en, 1'b0);
        tune_word(8'h93, 8'h80, 4'h1, 1'b1);
        tune_word(8'hff, 8'h00, 4'h1, 1'b0);
        // a byte with a foreign header must drop the half-built word
        u_ctrl.send_byte(8'h35);
        u_ctrl.send_byte(8'h45);
        tune_word(8'h21, 8'h43, 4'h2, 1'b1);
        check(tune_active, 1'b1);
        $display("test tune done");
    endtask

    task automatic t_exit;
        for (int k = 0; k < 2; k++) begin
            enter(8'h53);
            if (k == 0)
                u_ctrl.atn_pin = 1'b1;
            else
                key_pin = 1'b1;
            repeat (4) @(negedge clock);
            check(tune_active, 1'b0);
            check(level_loop_en, 1'b1);
            u_ctrl.atn_pin = 1'b0;
            key_pin = 1'b0;
            repeat (3) @(negedge clock);
        end
        $display("test exit done");
    endtask

    task automatic t_count;
        int n;
        u_ctrl.slow = 1'b1;
        enter(8'h46);
        check(count_active, 1'b1);
        check(left_dashes, 1'b1);
        check(tune_active, 1'b0);
        repeat (20) @(negedge clock);
        check(tx_valid, 1'b0);
        // input rises every second clock: 5120 ticks hold 2560 cycles
        // two whole groups, no delimiter between them
        for (int g = 1; g <= 2; g++) begin
            n = 0;
            while (u_ctrl.taken < 4 * g && n < 6000) begin
                n++;
                @(negedge clock);
            end
            check(u_ctrl.got[31:24], 8'hff);
            check(u_ctrl.got[23:16], 8'h00);
            check(u_ctrl.got[15:8], 8'h5f);
            check(u_ctrl.got[7:0], 8'h00);
        end
        u_ctrl.send_byte(8'h3f);
        check(count_active, 1'b0);
        check(tx_valid, 1'b0);
        enter(8'h46);
        u_ctrl.atn_pin = 1'b1;
        repeat (4) @(negedge clock);
        check(count_active, 1'b0);
        check(left_dashes, 1'b0);
        u_ctrl.atn_pin = 1'b0;
        u_ctrl.slow = 1'b0;
        repeat (3) @(negedge clock);
        $display("test count done");
    endtask

    task automatic t_sf;
        logic [7:0] want [3];
        want = '{8'h02, 8'h21, 8'h43};
        // re-read the tuning values before zeroing them
        for (int k = 0; k < 3; k++) begin
            sf_op(7'h37 + 7'(k), 1'b0);
            check(sf_rd_valid, 1'b1);
            check(sf_rd_data, want[k]);
            sf_op(7'h37 + 7'(k), 1'b1);
            check(src_load, 1'b1);
            repeat (PROG + 5) @(negedge clock);
            sf_op(7'h37 + 7'(k), 1'b0);
            check(sf_rd_data, 8'h00);
        end
        sf_op(7'h3a, 1'b0);
        check(sf_rd_valid, 1'b0);
        $display("test special functions done");
    endtask

    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        key_pin = 1'b0;
        sig_pin = 1'b0;
        sf_valid = 1'b0;
        sf_number = 7'h00;
        sf_zero = 1'b0;
        error_cnt = 0;
        cmp_count = 0;
        repeat (8) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        check(level_loop_en, 1'b1);
        check(left_dashes, 1'b0);
        $display("test reset done");
        t_tune;
        t_exit;
        t_count;
        t_sf;
        results;
    end

    // the tests need about ten and a half thousand cycles; far beyond is a hang
    initial begin
        #200000;
        error_cnt++;
        results;
    end
endmodule // test_rct_port

`default_nettype wire
